// ==== hdl/bsw_pkg.sv ====
// Constants for the secondary status and forwarding window register slice
//
// Summary of operation
// - Parity errors set secondary parity flag, bit 31
// - Secondary system error pin sets bit 30
// - Mastered transaction master-abort sets bit 29
// - Mastered transaction target-abort sets bit 28
// - Target-abort we signal sets bit 27
// - Device-select timing reads 01, read-only
// - Uncorrectable secondary data error sets bit 24
// - Back-to-back capable reads 1 in PCI mode
// - High-speed capable bit 21 always reads 1
// - Forward I/O only inside base/limit window
// - I/O limit nibble is bits 15:12, rest ones
// - I/O base nibble is bits 15:12, rest zero
// - Both I/O width codes read 0x1
// - Upper 16-bit fields give I/O bits 31:16
// - Memory limit gives bits 31:20, rest ones
// - Memory base gives bits 31:20, rest zero
// - Prefetch bounds bits 31:20; width codes 0x1
// - Upper prefetch base gives bits 63:32
// - Upper prefetch limit gives bits 63:32
// - Capability head pointer reads 0x80, read-only
package bsw_pkg;
  // Register offsets in configuration space
  localparam logic [7:0] OFF_SEC_STATUS_IO = 8'h1c;
  localparam logic [7:0] OFF_MEM_WINDOW = 8'h20;
  localparam logic [7:0] OFF_PF_WINDOW = 8'h24;
  localparam logic [7:0] OFF_PF_BASE_HI = 8'h28;
  localparam logic [7:0] OFF_PF_LIMIT_HI = 8'h2c;
  localparam logic [7:0] OFF_IO_WINDOW_HI = 8'h30;
  localparam logic [7:0] OFF_CAP_HEAD = 8'h34;
  // Values after reset
  localparam logic [31:0] RST_SEC_STATUS_IO = 32'h02a0_0101;
  localparam logic [31:0] RST_MEM_WINDOW = 32'h0000_0000;
  localparam logic [31:0] RST_PF_WINDOW = 32'h0001_0001;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CAP_HEAD = 32'h0000_0080;
  // Fixed read-only field values
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic [3:0] IO_WIDTH_CODE = 4'h1;
  localparam logic [3:0] PF_WIDTH_CODE = 4'h1;
  localparam logic [7:0] CAP_HEAD_PTR = 8'h80;
  // Implied low bits of window bounds
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [19:0] MEM_LOW_ONES = 20'hf_ffff;
  localparam logic [19:0] MEM_LOW_ZERO = 20'h0_0000;
  // Field positions in the secondary status word
  localparam int POS_PARITY = 31;
  localparam int POS_SERR = 30;
  localparam int POS_MABORT = 29;
  localparam int POS_TABORT_RX = 28;
  localparam int POS_TABORT_SIG = 27;
  localparam int POS_UNCORR = 24;
  localparam int POS_B2B = 23;
  localparam int POS_HI_SPEED = 21;
  // Sticky flag vector: index 5..0 holds bits 31,30,29,28,27,24
  localparam int FLAG_COUNT = 6;
  // Cycles from a taken configuration request to its acknowledge
  localparam int CFG_ACK_CYCLES = 1;
endpackage

// ==== hdl/bsw_sticky_flags.sv ====
// Sticky status flags, set by hardware events, cleared by writing one
`timescale 1ns/10ps
`default_nettype none
module bsw_sticky_flags #(
  parameter int N = 6
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  output logic [N-1:0] flag_out
);
  if (N < 1) begin : g_bad_n
    $error("bsw_sticky_flags: N must be at least 1");
  end

  // One flop per flag; a set in the clearing cycle wins so no event is lost
  for (genvar i = 0; i < N; i++) begin : g_flag
    logic flag_reg;
    logic flag_next;
    assign flag_next = set_in[i] | (flag_reg & ~clr_in[i]);
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        flag_reg <= 1'b0;
      end else if (ce_in) begin
        flag_reg <= flag_next;
      end
    end
    assign flag_out[i] = flag_reg;
  end
endmodule
`default_nettype wire

// ==== hdl/bsw_window_cmp.sv ====
// Inclusive address window compare, lower bound to upper bound
`timescale 1ns/10ps
`default_nettype none
module bsw_window_cmp #(
  parameter int W = 32
) (
  input wire logic [W-1:0] addr_in,
  input wire logic [W-1:0] lo_in,
  input wire logic [W-1:0] hi_in,
  output logic hit_out
);
  if (W < 2) begin : g_bad_w
    $error("bsw_window_cmp: W must be at least 2");
  end

  // An inverted window (base above limit) never hits, which disables it
  wire logic ge_lo;
  wire logic le_hi;
  assign ge_lo = (addr_in >= lo_in);
  assign le_hi = (addr_in <= hi_in);
  assign hit_out = ge_lo & le_hi;
endmodule
`default_nettype wire

// ==== hdl/bsw_sec_status_windows.sv ====
// Secondary status flags and I/O, memory and prefetch forwarding windows
`timescale 1ns/10ps
`default_nettype none
module bsw_sec_status_windows (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Configuration space access
  input wire logic cfg_req_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic cfg_ack_out,
  output logic [31:0] cfg_rdata_out,
  // Secondary bus events, one-cycle pulses; the serr pin and the PCI mode input are levels
  input wire logic addr_parity_tgt_in,
  input wire logic data_parity_wr_tgt_in,
  input wire logic data_parity_rd_mst_in,
  input wire logic secondary_system_error_pin_n_in,
  input wire logic master_abort_rx_in,
  input wire logic target_abort_rx_in,
  input wire logic target_abort_sig_in,
  input wire logic uncorrectable_data_error_in,
  input wire logic sec_pci_mode_in,
  // Forwarding decode requests
  input wire logic io_req_valid_in,
  input wire logic [31:0] io_req_addr_in,
  input wire logic mem_req_valid_in,
  input wire logic [31:0] mem_req_addr_in,
  input wire logic pf_req_valid_in,
  input wire logic [63:0] pf_req_addr_in,
  output logic io_fwd_out,
  output logic mem_fwd_out,
  output logic pf_fwd_out
);
  localparam int NF = bsw_pkg::FLAG_COUNT;

  // Writable window fields
  logic [3:0] io_limit_reg;
  logic [3:0] io_base_reg;
  logic [11:0] window_limit_reg;
  logic [11:0] mem_base_reg;
  logic [11:0] pf_limit_reg;
  logic [11:0] pf_base_reg;
  logic [31:0] pf_base_hi_reg;
  logic [31:0] pf_limit_hi_reg;
  logic [15:0] io_limit_hi_reg;
  logic [15:0] io_base_hi_reg;
  // Access answer
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] addr_q_reg;
  logic wr_q_reg;
  // Forward decisions
  logic io_fwd_reg;
  logic mem_fwd_reg;
  logic pf_fwd_reg;

  wire logic [NF-1:0] flags;
  wire logic [NF-1:0] flag_set;
  wire logic [NF-1:0] flag_clr;

  // Address decode of the configuration access
  wire logic take;
  wire logic wr_take;
  wire logic sel_status;
  wire logic sel_mem;
  wire logic sel_pf;
  wire logic sel_pfb_hi;
  wire logic sel_pfl_hi;
  wire logic sel_io_hi;
  wire logic sel_cap;
  assign take = ce_in & cfg_req_in;
  assign wr_take = take & cfg_wr_in;
  assign sel_status = (cfg_addr_in == bsw_pkg::OFF_SEC_STATUS_IO);
  assign sel_mem = (cfg_addr_in == bsw_pkg::OFF_MEM_WINDOW);
  assign sel_pf = (cfg_addr_in == bsw_pkg::OFF_PF_WINDOW);
  assign sel_pfb_hi = (cfg_addr_in == bsw_pkg::OFF_PF_BASE_HI);
  assign sel_pfl_hi = (cfg_addr_in == bsw_pkg::OFF_PF_LIMIT_HI);
  assign sel_io_hi = (cfg_addr_in == bsw_pkg::OFF_IO_WINDOW_HI);
  assign sel_cap = (cfg_addr_in == bsw_pkg::OFF_CAP_HEAD);

  // Read images; reserved bits are constant zero, never stored
  wire logic [31:0] img_status;
  wire logic [31:0] img_mem;
  wire logic [31:0] img_pf;
  wire logic [31:0] img_io_hi;
  wire logic [31:0] img_cap;
  assign img_status = {flags[5:1], bsw_pkg::DEVSEL_MEDIUM, flags[0],
                       sec_pci_mode_in, 1'b0, 1'b1, 5'h00,
                       io_limit_reg, bsw_pkg::IO_WIDTH_CODE,
                       io_base_reg, bsw_pkg::IO_WIDTH_CODE};
  assign img_mem = {window_limit_reg, 4'h0, mem_base_reg, 4'h0};
  assign img_pf = {pf_limit_reg, bsw_pkg::PF_WIDTH_CODE,
                   pf_base_reg, bsw_pkg::PF_WIDTH_CODE};
  assign img_io_hi = {io_limit_hi_reg, io_base_hi_reg};
  assign img_cap = {24'h00_0000, bsw_pkg::CAP_HEAD_PTR};

  // Read mux; an unmapped offset reads as zero
  wire logic [31:0] rd_word;
  assign rd_word = sel_status ? img_status :
                   sel_mem ? img_mem :
                   sel_pf ? img_pf :
                   sel_pfb_hi ? pf_base_hi_reg :
                   sel_pfl_hi ? pf_limit_hi_reg :
                   sel_io_hi ? img_io_hi :
                   sel_cap ? img_cap : 32'h0000_0000;

  // Byte-lane merge of write data over the current image
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return m;
  endfunction

  wire logic [31:0] wr_word;
  assign wr_word = lane_merge(rd_word, cfg_wdata_in, cfg_be_in);

  // Status flag events; the serr pin is active low and already synchronous
  assign flag_set[5] = addr_parity_tgt_in | data_parity_wr_tgt_in
                       | data_parity_rd_mst_in;
  assign flag_set[4] = ~secondary_system_error_pin_n_in;
  assign flag_set[3] = master_abort_rx_in;
  assign flag_set[2] = target_abort_rx_in;
  assign flag_set[1] = target_abort_sig_in;
  assign flag_set[0] = uncorrectable_data_error_in;

  // Write-one-to-clear, only through lane 3 which holds every flag
  wire logic clr_ok;
  assign clr_ok = wr_take & sel_status & cfg_be_in[3];
  assign flag_clr = clr_ok ? {cfg_wdata_in[31:27], cfg_wdata_in[24]} : '0;

  bsw_sticky_flags #(
    .N(NF)
  ) u_flags (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .set_in(flag_set),
    .clr_in(flag_clr),
    .flag_out(flags)
  );

  // I/O, memory and prefetch window registers; fixed fields drop writes
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_limit_reg <= bsw_pkg::RST_SEC_STATUS_IO[15:12];
      io_base_reg <= bsw_pkg::RST_SEC_STATUS_IO[7:4];
      window_limit_reg <= bsw_pkg::RST_MEM_WINDOW[31:20];
      mem_base_reg <= bsw_pkg::RST_MEM_WINDOW[15:4];
      pf_limit_reg <= bsw_pkg::RST_PF_WINDOW[31:20];
      pf_base_reg <= bsw_pkg::RST_PF_WINDOW[15:4];
    end else if (wr_take) begin
      if (sel_status) begin
        io_limit_reg <= wr_word[15:12];
        io_base_reg <= wr_word[7:4];
      end
      if (sel_mem) begin
        window_limit_reg <= wr_word[31:20];
        mem_base_reg <= wr_word[15:4];
      end
      if (sel_pf) begin
        pf_limit_reg <= wr_word[31:20];
        pf_base_reg <= wr_word[15:4];
      end
    end
  end

  // Upper halves of the I/O and prefetch bounds
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pf_base_hi_reg <= bsw_pkg::RST_ZERO;
      pf_limit_hi_reg <= bsw_pkg::RST_ZERO;
      io_limit_hi_reg <= bsw_pkg::RST_ZERO[31:16];
      io_base_hi_reg <= bsw_pkg::RST_ZERO[15:0];
    end else if (wr_take) begin
      if (sel_pfb_hi) begin
        pf_base_hi_reg <= wr_word;
      end
      if (sel_pfl_hi) begin
        pf_limit_hi_reg <= wr_word;
      end
      if (sel_io_hi) begin
        io_limit_hi_reg <= wr_word[31:16];
        io_base_hi_reg <= wr_word[15:0];
      end
    end
  end

  // Answer one cycle after the request; a write answers with zero read data
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= bsw_pkg::RST_ZERO;
      addr_q_reg <= 8'h00;
      wr_q_reg <= 1'b0;
    end else if (ce_in) begin
      ack_reg <= cfg_req_in;
      if (cfg_req_in) begin
        rdata_reg <= cfg_wr_in ? 32'h0000_0000 : rd_word;
        addr_q_reg <= cfg_addr_in;
        wr_q_reg <= cfg_wr_in;
      end
    end
  end

  assign cfg_ack_out = ack_reg;
  assign cfg_rdata_out = rdata_reg;

  // Full bounds assembled from the stored fields and the implied low bits
  wire logic [31:0] io_lo;
  wire logic [31:0] io_hi;
  wire logic [31:0] mem_lo;
  wire logic [31:0] mem_hi;
  wire logic [63:0] pf_lo;
  wire logic [63:0] pf_hi;
  assign io_lo = {io_base_hi_reg, io_base_reg, bsw_pkg::IO_LOW_ZERO};
  assign io_hi = {io_limit_hi_reg, io_limit_reg, bsw_pkg::IO_LOW_ONES};
  assign mem_lo = {mem_base_reg, bsw_pkg::MEM_LOW_ZERO};
  assign mem_hi = {window_limit_reg, bsw_pkg::MEM_LOW_ONES};
  assign pf_lo = {pf_base_hi_reg, pf_base_reg, bsw_pkg::MEM_LOW_ZERO};
  assign pf_hi = {pf_limit_hi_reg, pf_limit_reg, bsw_pkg::MEM_LOW_ONES};

  wire logic io_in_win;
  wire logic mem_in_win;
  wire logic pf_in_win;

  bsw_window_cmp #(
    .W(32)
  ) u_io_cmp (
    .addr_in(io_req_addr_in),
    .lo_in(io_lo),
    .hi_in(io_hi),
    .hit_out(io_in_win)
  );

  bsw_window_cmp #(
    .W(32)
  ) u_mem_cmp (
    .addr_in(mem_req_addr_in),
    .lo_in(mem_lo),
    .hi_in(mem_hi),
    .hit_out(mem_in_win)
  );

  bsw_window_cmp #(
    .W(64)
  ) u_pf_cmp (
    .addr_in(pf_req_addr_in),
    .lo_in(pf_lo),
    .hi_in(pf_hi),
    .hit_out(pf_in_win)
  );

  // Forward decisions are registered so the datapath sees a clean level
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_fwd_reg <= 1'b0;
      mem_fwd_reg <= 1'b0;
      pf_fwd_reg <= 1'b0;
    end else if (ce_in) begin
      io_fwd_reg <= io_req_valid_in & io_in_win;
      mem_fwd_reg <= mem_req_valid_in & mem_in_win;
      pf_fwd_reg <= pf_req_valid_in & pf_in_win;
    end
  end

  assign io_fwd_out = io_fwd_reg;
  assign mem_fwd_out = mem_fwd_reg;
  assign pf_fwd_out = pf_fwd_reg;

  // Checks on the flags, fixed fields and forwarding
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_parity_flag_set: assert property (
    ce_in && (addr_parity_tgt_in || data_parity_wr_tgt_in || data_parity_rd_mst_in)
    |=> flags[5])
    else $error("parity event did not set flag");

  // The pin is a level, so every enabled cycle it is low must leave the flag set
  a_serr_flag_set: assert property (
    ce_in && !secondary_system_error_pin_n_in |=> flags[4])
    else $error("system error pin not recorded");

  a_mabort_flag_set: assert property (
    ce_in && master_abort_rx_in |=> flags[3])
    else $error("master abort not recorded");

  a_tabort_rx_set: assert property (
    ce_in && target_abort_rx_in |=> flags[2])
    else $error("received target abort not recorded");

  a_tabort_sig_set: assert property (
    ce_in && target_abort_sig_in |=> flags[1])
    else $error("signalled target abort not recorded");

  a_uncorr_flag_set: assert property (
    ce_in && uncorrectable_data_error_in |=> flags[0])
    else $error("uncorrectable data error not recorded");

  a_status_fixed_bits: assert property (
    cfg_ack_out && !wr_q_reg && addr_q_reg == bsw_pkg::OFF_SEC_STATUS_IO
    |-> cfg_rdata_out[26:25] == 2'b01 && cfg_rdata_out[bsw_pkg::POS_HI_SPEED]
        && cfg_rdata_out[11:8] == 4'h1 && cfg_rdata_out[3:0] == 4'h1
        && cfg_rdata_out[22] == 1'b0 && cfg_rdata_out[20:16] == 5'h00)
    else $error("fixed status fields wrong");

  a_cap_head_value: assert property (
    cfg_ack_out && !wr_q_reg && addr_q_reg == bsw_pkg::OFF_CAP_HEAD
    |-> cfg_rdata_out == 32'h0000_0080)
    else $error("capability head pointer wrong");

  a_w1c_clears: assert property (
    flags[4] && clr_ok && cfg_wdata_in[bsw_pkg::POS_SERR]
    && secondary_system_error_pin_n_in |=> !flags[4])
    else $error("write one did not clear flag");

  a_io_window_fwd: assert property (
    ce_in && io_req_valid_in
    && ({io_req_addr_in[31:16], io_req_addr_in[15:12]} > {io_limit_hi_reg, io_limit_reg}
     || {io_req_addr_in[31:16], io_req_addr_in[15:12]} < {io_base_hi_reg, io_base_reg})
    |=> !io_fwd_out)
    else $error("I/O forwarded outside window");

  // Every taken request is answered exactly one enabled cycle later
  a_ack_follows_req: assert property (
    ce_in && cfg_req_in |=> cfg_ack_out)
    else $error("request not answered");

  a_ack_one_cycle: assert property (
    ce_in && !cfg_req_in |=> !cfg_ack_out)
    else $error("answer without a request");

  // Clock enable low must freeze the flags and the answer
  a_ce_freezes_state: assert property (
    !ce_in |=> $stable(flags) && $stable(cfg_ack_out) && $stable(cfg_rdata_out))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ==== test/bsw_sec_agent.sv ====
// Secondary bus agent model that raises bus error events toward the bridge
`timescale 1ns/10ps
`default_nettype none
module bsw_sec_agent (
  input wire logic sys_clk_in,
  input wire logic [7:0] fire_in,
  output var logic [7:0] evt_out,
  output var logic serr_n_out
);
  // Idle: no events, system error line resting at its pull-up level
  initial begin
    evt_out = 8'h00;
    serr_n_out = 1'b1;
  end
  // Launch one cycle after the command, off the falling edge, so the bridge samples a whole pulse
  always @(negedge sys_clk_in) begin
    evt_out <= fire_in;
    serr_n_out <= ~fire_in[3];
  end
endmodule
`default_nettype wire

// ==== test/bsw_sec_status_windows_tb.sv ====
// Self-checking bench for the secondary status and forwarding window registers
`timescale 1ns/10ps
`default_nettype none
module bsw_sec_status_windows_tb;
  logic sys_clk_in, rstn_in, ce_in, req, wr, ack, pci_mode, serr_n;
  logic iov, memv, pfv, io_fwd, mem_fwd, pf_fwd;
  logic [7:0] addr, fire, evt, ra;
  logic [3:0] be;
  logic [31:0] wdata, rdata, ioa, mema, flags, rw;
  logic [63:0] pfa;
  logic [31:0] m[6];
  int miscompares, total_checks, seed;
  int pos[8] = '{31, 31, 31, 30, 29, 28, 27, 24};

  bsw_sec_agent agent (.sys_clk_in(sys_clk_in), .fire_in(fire), .evt_out(evt),
    .serr_n_out(serr_n));

  bsw_sec_status_windows DUT (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .cfg_req_in(req), .cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_be_in(be),
    .cfg_wdata_in(wdata), .cfg_ack_out(ack), .cfg_rdata_out(rdata),
    .addr_parity_tgt_in(evt[0]), .data_parity_wr_tgt_in(evt[1]),
    .data_parity_rd_mst_in(evt[2]), .secondary_system_error_pin_n_in(serr_n),
    .master_abort_rx_in(evt[4]), .target_abort_rx_in(evt[5]),
    .target_abort_sig_in(evt[6]), .uncorrectable_data_error_in(evt[7]),
    .sec_pci_mode_in(pci_mode), .io_req_valid_in(iov), .io_req_addr_in(ioa),
    .mem_req_valid_in(memv), .mem_req_addr_in(mema), .pf_req_valid_in(pfv),
    .pf_req_addr_in(pfa), .io_fwd_out(io_fwd), .mem_fwd_out(mem_fwd),
    .pf_fwd_out(pf_fwd)
  );

  // 40 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Model read value; fixed fields are merged here, raw writes kept in m
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h1c: exp_rd = flags | 32'h0220_0101 | {8'h00, pci_mode, 23'h0} | (m[0] & 32'h0000_f0f0);
      8'h20: exp_rd = m[1] & 32'hfff0_fff0;
      8'h24: exp_rd = (m[2] & 32'hfff0_fff0) | 32'h0001_0001;
      8'h28: exp_rd = m[3];
      8'h2c: exp_rd = m[4];
      8'h30: exp_rd = m[5];
      8'h34: exp_rd = 32'h0000_0080;
      default: exp_rd = 32'h0000_0000;
    endcase
  endfunction

  // Model write: byte lanes, write-one-clear of the status flags through lane 3
  function automatic void mwr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] bm;
    bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    if (a == 8'h1c) flags = flags & ~(d & bm & 32'hf900_0000);
    if (a >= 8'h1c && a <= 8'h30) m[(a - 8'h1c) >> 2] = (m[(a - 8'h1c) >> 2] & ~bm) | (d & bm);
  endfunction

  // One configuration access; answer expected at the falling edge after the taking edge
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] e;
    e = w ? 32'h0000_0000 : exp_rd(a);
    @(negedge sys_clk_in);
    {req, wr, addr, be, wdata} = {1'b1, w, a, b, d};
    @(negedge sys_clk_in);
    req = 1'b0;
    chk("cfg_ack", ack, 1'b1);
    chk($sformatf("rdata_%h", a), rdata, e);
    if (w) mwr(a, b, d);
  endtask

  // Pulse one secondary event source through the agent
  task automatic raise(input int k);
    @(negedge sys_clk_in);
    fire <= 8'h01 << k;
    @(negedge sys_clk_in);
    fire <= 8'h00;
    @(negedge sys_clk_in);
    flags[pos[k]] = 1'b1;
  endtask

  // Decode request on all three windows; s picks a bound, a neighbour or a random address
  task automatic dec(input int s);
    logic [31:0] il, ih, ml, mh;
    logic [63:0] pl, ph, r;
    il = {m[5][15:0], m[0][7:4], 12'h000};
    ih = {m[5][31:16], m[0][15:12], 12'hfff};
    ml = {m[1][15:4], 20'h0_0000};
    mh = {m[1][31:20], 20'hf_ffff};
    pl = {m[3], m[2][15:4], 20'h0_0000};
    ph = {m[4], m[2][31:20], 20'hf_ffff};
    r = {$random(seed), $random(seed)};
    @(negedge sys_clk_in);
    {iov, memv, pfv} = 3'h7;
    case (s)
      0: {ioa, mema, pfa} = {il, ml, pl};
      1: {ioa, mema, pfa} = {ih, mh, ph};
      2: {ioa, mema, pfa} = {il - 32'h1, ml - 32'h1, pl - 64'h1};
      3: {ioa, mema, pfa} = {ih + 32'h1, mh + 32'h1, ph + 64'h1};
      default: {ioa, mema, pfa} = {r[31:0], r[63:32], r};
    endcase
    @(negedge sys_clk_in);
    {iov, memv, pfv} = 3'h0;
    chk("io_fwd", io_fwd, ioa >= il && ioa <= ih);
    chk("mem_fwd", mem_fwd, mema >= ml && mema <= mh);
    chk("pf_fwd", pf_fwd, pfa >= pl && pfa <= ph);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 85706;
    {rstn_in, ce_in, pci_mode, req, wr, iov, memv, pfv} = 8'h60;
    {fire, addr, be, wdata, ioa, mema, pfa} = '0;
    flags = 32'h0000_0000;
    foreach (m[i]) m[i] = 32'h0000_0000;
    repeat (8) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    // Reset values, fixed fields and unmapped offsets
    for (int a = 0; a < 16; a++) cfg(1'b0, 8'(8'h10 + 4 * a), 4'hf, 32'h0000_0000);
    // Random lane writes, read-only bits must not move
    for (int j = 0; j < 40; j++) begin
      rw = $random(seed);
      ra = 8'h1c + {3'h0, rw[2:0], 2'h0};
      cfg(1'b1, ra, rw[6:3], $random(seed));
      cfg(1'b0, ra, 4'hf, 32'h0000_0000);
    end
    // Back-to-back capability follows the secondary mode
    pci_mode = 1'b0;
    cfg(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
    pci_mode = 1'b1;
    // Clock enable low: a write and a master abort must both go unseen, with no answer
    @(negedge sys_clk_in);
    {ce_in, req, wr, addr, be, wdata} = {1'b0, 1'b1, 1'b1, 8'h28, 4'hf, 32'h5a5a_a5a5};
    fire <= 8'h10;
    repeat (2) @(negedge sys_clk_in);
    fire <= 8'h00;
    repeat (2) @(negedge sys_clk_in);
    chk("cfg_ack_frozen", ack, 1'b0);
    {ce_in, req} = 2'b10;
    cfg(1'b0, 8'h28, 4'hf, 32'h0000_0000);
    cfg(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
    // Every event sets its flag; clears without lane 3 or with zero data leave it set
    for (int k = 0; k < 8; k++) begin
      raise(k);
      cfg(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
      cfg(1'b1, 8'h1c, 4'h7, 32'hffff_ffff);
      cfg(1'b1, 8'h1c, 4'hf, 32'h0000_0000);
      cfg(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
      cfg(1'b1, 8'h1c, 4'hf, 32'h1 << pos[k]);
      cfg(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
    end
    // Windows reprogrammed every five decodes, bounds and neighbours probed
    for (int j = 0; j < 100; j++) begin
      if (j % 5 == 0) begin
        for (int k = 0; k < 6; k++) cfg(1'b1, 8'(8'h1c + 4 * k), 4'hf, $random(seed));
      end
      dec(j % 5);
    end
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
